// *** src/frtcc_pkg.sv ***
package frtcc_pkg;
   // Register addresses
   localparam logic [15:0] ADDR_MODE_CTRL  = 16'hff48;
   localparam logic [15:0] ADDR_PORT2_DIR  = 16'hff22;
   localparam logic [15:0] ADDR_PORT3_DIR  = 16'hff23;
   localparam logic [15:0] ADDR_COMPARE    = 16'hff18;
   localparam logic [15:0] ADDR_COUNTER    = 16'hff1a;
   localparam logic [15:0] ADDR_CAPTURE    = 16'hff1c;
   localparam logic [15:0] ADDR_PORT2_DATA = 16'hff02;
   // Mode control field positions, then port pin positions
   localparam int BIT_OUT_DATA   = 7;
   localparam int BIT_OVF        = 6;
   localparam int BIT_CAP_HI     = 5;
   localparam int BIT_CAP_LO     = 4;
   localparam int BIT_INV_EN     = 3;
   localparam int BIT_CLK_HI     = 2;
   localparam int BIT_CLK_LO     = 1;
   localparam int BIT_OUT_EN     = 0;
   localparam int BIT_OUT_PIN    = 6;
   localparam int BIT_CAP_PIN    = 0;
   // Reset values
   localparam logic [7:0]  RST_MODE_CTRL = 8'h00;
   localparam logic [7:0]  RST_PORT2_DIR = 8'hff;
   localparam logic [7:0]  RST_PORT3_DIR = 8'hff;
   localparam logic [7:0]  RST_PORT2_DAT = 8'h00;
   localparam logic [15:0] RST_COMPARE   = 16'hffff;
   localparam logic [15:0] RST_COUNTER   = 16'h0000;
   localparam logic [15:0] RST_CAPTURE   = 16'h0000;
   // Prescaler divide terminal counts (divide minus one)
   localparam logic [6:0]  DIV4_LAST   = 7'h03;
   localparam logic [6:0]  DIV32_LAST  = 7'h1f;
   localparam logic [6:0]  DIV128_LAST = 7'h7f;
   // Capture edge select codes
   typedef enum logic [1:0] {
      FRTCC_CAP_OFF  = 2'h0,
      FRTCC_CAP_RISE = 2'h1,
      FRTCC_CAP_FALL = 2'h2,
      FRTCC_CAP_BOTH = 2'h3
   } frtcc_cap_t;
   // Count clock select codes
   typedef enum logic [1:0] {
      FRTCC_CLK_DIV1   = 2'h0,
      FRTCC_CLK_DIV4   = 2'h1,
      FRTCC_CLK_DIV32  = 2'h2,
      FRTCC_CLK_DIV128 = 2'h3
   } frtcc_clk_t;
endpackage

// *** src/frtcc_timer.sv ***
`timescale 1ns/1ns
// Operation
// - Reset clears the mode control register to zero.
// - Bit 7 reads the timer output level; writes ignored.
// - Bit 6 set on counter wrap; cleared by reset or writing zero.
// - Bits 5:4 select capture edge: off, rising, falling, both.
// - Bit 3 permits output toggling on compare match.
// - Bits 2:1 select count rate: divide by 1, 4, 32, 128.
// - Bit 0 hands pin to timer output, else ordinary port.
// - Match of counter and compare raises interrupt; counter keeps running.
// - Matches recur once per full 65536-count wrap.
// - With inversion and output enable set, output toggles on every match.
// - Direction bit 0 drives pin, 1 releases; port 2 resets all ones.
// - Capture edge latches counter within three clocks; held until next.
// - Timer output starts low when output enable is set.
// - Reset loads compare register with all ones.
// - Reset clears counter, which then free-runs immediately.
module frtcc_timer
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic [15:0] ADDR,
   input  wire logic        WR_EN,
   input  wire logic        WR_WORD,
   input  wire logic [15:0] WR_DATA,
   input  wire logic        RD_EN,
   output logic      [15:0] RD_DATA,
   input  wire logic        CAPTURE_TRIGGER_PIN,
   output logic             TIMER_OUTPUT_PIN,
   output logic             TIMER_OUTPUT_PIN_OE,
   output logic             COMPARE_IRQ
);

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]  mode_ctrl;
   logic [7:0]  next_mode_ctrl;
   logic [7:0]  port2_direction;
   logic [7:0]  next_port2_direction;
   logic [7:0]  port3_direction;
   logic [7:0]  next_port3_direction;
   logic [7:0]  port_two;
   logic [7:0]  next_port_two;
   logic [15:0] compare_value;
   logic [15:0] next_compare_value;
   logic [15:0] free_run_counter;
   logic [15:0] next_free_run_counter;
   logic [15:0] capture_value;
   logic [15:0] next_capture_value;
   logic        output_data_level;
   logic        next_output_data_level;
   logic [6:0]  prescale;
   logic [6:0]  next_prescale;
   logic        cap_meta;
   logic        cap_sync;
   logic        cap_prev;
   logic        irq;
   logic        next_irq;
   logic        count_en;
   logic        cap_hit;
   logic        match;
   logic        wr_mode;
   logic [6:0]  div_last;

   assign wr_mode = WR_EN && (ADDR == frtcc_pkg::ADDR_MODE_CTRL);

   ////////////////////////////////////////////////////////////////////////
   // Prescaler: one-cycle count enable instead of a derived clock
   always_comb
   begin
      unique case (frtcc_pkg::frtcc_clk_t'(mode_ctrl[frtcc_pkg::BIT_CLK_HI:
                                                     frtcc_pkg::BIT_CLK_LO]))
         frtcc_pkg::FRTCC_CLK_DIV1:   div_last = 7'h00;
         frtcc_pkg::FRTCC_CLK_DIV4:   div_last = frtcc_pkg::DIV4_LAST;
         frtcc_pkg::FRTCC_CLK_DIV32:  div_last = frtcc_pkg::DIV32_LAST;
         frtcc_pkg::FRTCC_CLK_DIV128: div_last = frtcc_pkg::DIV128_LAST;
      endcase
      // Compare against the masked count so a rate change never stalls
      count_en = ((prescale & div_last) == div_last);
      next_prescale = prescale + 7'h01;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
         prescale <= 7'h00;
      else
         prescale <= next_prescale;
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture pin synchroniser and edge detect
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         cap_meta <= 1'b0;
         cap_sync <= 1'b0;
         cap_prev <= 1'b0;
      end
      else
      begin
         cap_meta <= CAPTURE_TRIGGER_PIN;
         cap_sync <= cap_meta;
         cap_prev <= cap_sync;
      end
   end

   always_comb
   begin
      unique case (frtcc_pkg::frtcc_cap_t'(mode_ctrl[frtcc_pkg::BIT_CAP_HI:
                                                     frtcc_pkg::BIT_CAP_LO]))
         frtcc_pkg::FRTCC_CAP_OFF:  cap_hit = 1'b0;
         frtcc_pkg::FRTCC_CAP_RISE: cap_hit = cap_sync && !cap_prev;
         frtcc_pkg::FRTCC_CAP_FALL: cap_hit = !cap_sync && cap_prev;
         frtcc_pkg::FRTCC_CAP_BOTH: cap_hit = cap_sync != cap_prev;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter: never cleared on match, so matches recur once per wrap
   assign match = (free_run_counter == compare_value);

   always_comb
   begin
      next_free_run_counter = free_run_counter;
      if (count_en)
         next_free_run_counter = free_run_counter + 16'h0001;
   end

   // Restarts from zero and free-runs on the first enable after reset
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
         free_run_counter <= frtcc_pkg::RST_COUNTER;
      else
         free_run_counter <= next_free_run_counter;
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare register: one word write, or one byte at a time
   always_comb
   begin
      next_compare_value = compare_value;
      if (WR_EN && ADDR == frtcc_pkg::ADDR_COMPARE)
      begin
         if (WR_WORD)
            next_compare_value = WR_DATA;
         else
            next_compare_value[7:0] = WR_DATA[7:0];
      end
      // A half-written value can match; software masks the request meanwhile
      if (WR_EN && ADDR == (frtcc_pkg::ADDR_COMPARE + 16'h0001))
         next_compare_value[15:8] = WR_DATA[7:0];
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
         compare_value <= frtcc_pkg::RST_COMPARE;
      else
         compare_value <= next_compare_value;
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture register: holds until the next selected edge
   always_comb
   begin
      next_capture_value = capture_value;
      if (cap_hit)
         next_capture_value = free_run_counter;
   end

   // Cleared at reset so an early read is never unknown
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
         capture_value <= frtcc_pkg::RST_CAPTURE;
      else
         capture_value <= next_capture_value;
   end

   ////////////////////////////////////////////////////////////////////////
   // Match pulse and timer output data
   always_comb
   begin
      next_output_data_level = output_data_level;
      next_irq               = 1'b0;
      // One pulse per count period in which the match holds
      if (match && count_en)
      begin
         next_irq = 1'b1;
         if (mode_ctrl[frtcc_pkg::BIT_INV_EN])
            next_output_data_level = !output_data_level;
      end
      // Output data parked low while the pin is not handed over
      if (!mode_ctrl[frtcc_pkg::BIT_OUT_EN])
         next_output_data_level = 1'b0;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         output_data_level <= 1'b0;
         irq               <= 1'b0;
      end
      else
      begin
         output_data_level <= next_output_data_level;
         irq               <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode control register
   always_comb
   begin
      next_mode_ctrl = mode_ctrl;
      if (wr_mode)
      begin
         // Bit 7 is read-only; overflow bit can only be cleared by software
         next_mode_ctrl[5:0] = WR_DATA[5:0];
         if (!WR_DATA[frtcc_pkg::BIT_OVF])
            next_mode_ctrl[frtcc_pkg::BIT_OVF] = 1'b0;
      end
      // Wrap sets the flag; set wins over a same-cycle clear
      if (count_en && free_run_counter == 16'hffff)
         next_mode_ctrl[frtcc_pkg::BIT_OVF] = 1'b1;
      // Stored bit 7 unused; reads show the live output data instead
      next_mode_ctrl[frtcc_pkg::BIT_OUT_DATA] = 1'b0;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
         mode_ctrl <= frtcc_pkg::RST_MODE_CTRL;
      else
         mode_ctrl <= next_mode_ctrl;
   end

   ////////////////////////////////////////////////////////////////////////
   // Port direction and latch registers
   always_comb
   begin
      next_port2_direction = port2_direction;
      next_port3_direction = port3_direction;
      next_port_two        = port_two;
      if (WR_EN && ADDR == frtcc_pkg::ADDR_PORT2_DIR)
         next_port2_direction = WR_DATA[7:0];
      if (WR_EN && ADDR == frtcc_pkg::ADDR_PORT3_DIR)
         next_port3_direction = WR_DATA[7:0];
      if (WR_EN && ADDR == frtcc_pkg::ADDR_PORT2_DATA)
         next_port_two = WR_DATA[7:0];
   end

   // Directions reset to input so no pin is driven before software acts
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         port2_direction <= frtcc_pkg::RST_PORT2_DIR;
         port3_direction <= frtcc_pkg::RST_PORT3_DIR;
         port_two        <= frtcc_pkg::RST_PORT2_DAT;
      end
      else
      begin
         port2_direction <= next_port2_direction;
         port3_direction <= next_port3_direction;
         port_two        <= next_port_two;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; bit 7 shows live output data
   always_comb
   begin
      RD_DATA = 16'h0000;
      if (RD_EN)
      begin
         unique case (ADDR)
            frtcc_pkg::ADDR_MODE_CTRL:
               RD_DATA = {8'h00, output_data_level, mode_ctrl[6:0]};
            frtcc_pkg::ADDR_PORT2_DIR:  RD_DATA = {8'h00, port2_direction};
            frtcc_pkg::ADDR_PORT3_DIR:  RD_DATA = {8'h00, port3_direction};
            frtcc_pkg::ADDR_PORT2_DATA: RD_DATA = {8'h00, port_two};
            frtcc_pkg::ADDR_COMPARE:    RD_DATA = compare_value;
            frtcc_pkg::ADDR_COUNTER:    RD_DATA = free_run_counter;
            frtcc_pkg::ADDR_CAPTURE:    RD_DATA = capture_value;
            default:                    RD_DATA = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin: timer data when enabled, port latch otherwise; buffer off on 1
   assign TIMER_OUTPUT_PIN = mode_ctrl[frtcc_pkg::BIT_OUT_EN] ? output_data_level
                           : port_two[frtcc_pkg::BIT_OUT_PIN];
   assign TIMER_OUTPUT_PIN_OE = !port2_direction[frtcc_pkg::BIT_OUT_PIN];
   assign COMPARE_IRQ = irq;

endmodule

// *** verif/frtcc_timer_monitor.sv ***
`timescale 1ns/1ns
module frtcc_timer_monitor
(
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   input wire logic [15:0] ADDR,
   input wire logic        WR_EN,
   input wire logic        WR_WORD,
   input wire logic [15:0] WR_DATA,
   input wire logic        RD_EN,
   input wire logic [15:0] RD_DATA,
   input wire logic        CAPTURE_TRIGGER_PIN,
   input wire logic        TIMER_OUTPUT_PIN,
   input wire logic        TIMER_OUTPUT_PIN_OE,
   input wire logic        COMPARE_IRQ
);
   default clocking mc @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////
   // A read parked on one address is our window into a register
   wire rd_mode = RD_EN && ADDR == frtcc_pkg::ADDR_MODE_CTRL;
   wire rd_cnt = RD_EN && ADDR == frtcc_pkg::ADDR_COUNTER;
   wire rd_cap = RD_EN && ADDR == frtcc_pkg::ADDR_CAPTURE;
   wire rd_dir = RD_EN && ADDR == frtcc_pkg::ADDR_PORT2_DIR;
   // Six quiet cycles drain the synchroniser and edge detect
   sequence cap_quiet;
      (rd_cap && $stable(CAPTURE_TRIGGER_PIN))[*6];
   endsequence
   sequence out_quiet;
      (rd_mode && RD_DATA[0] && !RD_DATA[3])[*2];
   endsequence
   sequence ovf_seen;
      (rd_mode && RD_DATA[6] && !WR_EN) ##1 rd_mode;
   endsequence
   ////////////////////////////////////////
   dir_oe_a: assert property (rd_dir |-> RD_DATA[6] == !TIMER_OUTPUT_PIN_OE)
      else $error("pin enable differs from direction");
   out_level_a: assert property (rd_mode && RD_DATA[0]
      |-> TIMER_OUTPUT_PIN == RD_DATA[7])
      else $error("pin differs from output data");
   irq_pulse_a: assert property (COMPARE_IRQ |=> !COMPARE_IRQ)
      else $error("compare request too long");
   match_flip_a: assert property (COMPARE_IRQ && rd_mode && RD_DATA[3] && RD_DATA[0]
      |-> TIMER_OUTPUT_PIN != $past(TIMER_OUTPUT_PIN))
      else $error("no toggle on match");
   quiet_out_a: assert property (out_quiet |-> $stable(RD_DATA[7]))
      else $error("output moved with inversion off");
   cap_hold_a: assert property (cap_quiet |-> $stable(RD_DATA))
      else $error("capture moved without edge");
   ovf_stick_a: assert property (ovf_seen |-> RD_DATA[6])
      else $error("overflow flag lost");
   cnt_step_a: assert property (rd_cnt ##1 rd_cnt
      |-> 16'(RD_DATA - $past(RD_DATA)) <= 16'h0001)
      else $error("counter jumped");
endmodule

// *** verif/frtcc_pin_partner.sv ***
`timescale 1ns/1ns
module frtcc_pin_partner
(
   input  wire logic clk,
   input  wire logic timer_pin,
   input  wire logic timer_oe,
   output logic      trigger,
   output logic      line_level
);
   // Trigger rests low; edges launch only at a clock edge
   initial trigger = 1'b0;
   initial line_level = 1'b0;
   // No pull on the pin, so a released line must not look driven
   always @(posedge clk)
      line_level <= timer_oe ? timer_pin : !line_level;
   task automatic drive(input logic lvl);
      @(posedge clk);
      trigger <= lvl;
   endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb;
   localparam logic [15:0] a_mode = frtcc_pkg::ADDR_MODE_CTRL;
   localparam logic [15:0] a_cnt = frtcc_pkg::ADDR_COUNTER;
   localparam logic [15:0] a_cap = frtcc_pkg::ADDR_CAPTURE;
   localparam logic [15:0] a_cmp = frtcc_pkg::ADDR_COMPARE;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wr_en = 1'b0;
   logic        wr_word = 1'b0;
   logic        rd_en = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wr_data = 16'h0000;
   logic [15:0] rd_data, v, c0, cmp;
   logic        trig, pin, oe, irq, line;
   int          fails = 0;
   int          samples_checked = 0;
   ////////////////////////////////////////
   frtcc_timer dut_u (.SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_EN(wr_en),
      .WR_WORD(wr_word), .WR_DATA(wr_data), .RD_EN(rd_en), .RD_DATA(rd_data),
      .CAPTURE_TRIGGER_PIN(trig), .TIMER_OUTPUT_PIN(pin), .TIMER_OUTPUT_PIN_OE(oe),
      .COMPARE_IRQ(irq));
   frtcc_pin_partner partner_u (.clk(clk), .timer_pin(pin), .timer_oe(oe),
      .trigger(trig), .line_level(line));
   initial
      forever #5 clk = ~clk;
   ////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One-cycle write strobe; the read strobe drops meanwhile
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w = 1'b0);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_word <= w;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Read data is combinational, so sample once the edge has landed
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      #1;
      d = rd_data;
   endtask
   task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
      rd(a, v);
      check(v, exp);
   endtask
   task automatic summarize();
      $display("checked %0d, failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////
   // Reset values, then writes to the read-only and sticky bits
   task automatic t_reset_mode();
      chk_rd(a_mode, 16'h0000);
      chk_rd(frtcc_pkg::ADDR_PORT2_DIR, 16'h00ff);
      chk_rd(a_cmp, 16'hffff);
      chk_rd(16'hff00, 16'h0000);
      check({15'h0, oe}, 16'h0000);
      wr(a_mode, 16'h00ff);
      chk_rd(a_mode, 16'h003f);
   endtask
   // Each rate over exactly two of its own periods
   task automatic t_rates();
      int div[4] = '{1, 4, 32, 128};
      for (int k = 0; k < 4; k++)
      begin
         wr(a_mode, 16'(k << 1));
         rd(a_cnt, c0);
         repeat (2 * div[k] - 1) @(posedge clk);
         chk_rd(a_cnt, c0 + 16'h0002);
      end
   endtask
   // Every edge code against one rise and one fall
   task automatic t_capture();
      logic [15:0] old;
      wr(frtcc_pkg::ADDR_PORT3_DIR, 16'h00ff);
      for (int c = 0; c < 4; c++)
         for (int e = 1; e >= 0; e--)
         begin
            wr(a_mode, 16'(c << 4));
            rd(a_cap, old);
            partner_u.drive(e[0]);
            rd(a_cnt, c0);
            repeat (8) rd(a_cap, v);
            if ((e == 1) ? c[0] : c[1])
               check({15'h0, 16'(v - c0) <= 16'h0004}, 16'h0001);
            else
               check(v, old);
         end
   endtask
   // Two matches a full wrap apart, with inversion on
   task automatic t_output();
      int n;
      wr(a_mode, 16'h0000);
      wr(a_cmp, 16'h1234, 1'b1);
      chk_rd(a_cmp, 16'h1234);
      rd(a_cnt, cmp);
      cmp = cmp + 16'd60;
      wr(16'hff19, {8'h00, cmp[15:8]});
      wr(a_cmp, {8'h00, cmp[7:0]});
      chk_rd(a_cmp, cmp);
      wr(frtcc_pkg::ADDR_PORT2_DATA, 16'h0000);
      wr(frtcc_pkg::ADDR_PORT2_DIR, 16'h00bf);
      wr(a_mode, 16'h0009);
      chk_rd(a_mode, 16'h0009);
      check({14'h0, oe, pin}, 16'h0002);
      for (int k = 0; k < 2; k++)
      begin
         n = 0;
         do
         begin
            rd(a_mode, v);
            n++;
         end
         while (irq !== 1'b1 && n < 70000);
         check({15'h0, pin}, 16'(1 - k));
      end
      check(16'(n - 65520), 16'h0010);
      chk_rd(a_cnt, cmp + 16'h0002);
      chk_rd(a_mode, 16'h0049);
      wr(a_mode, 16'h0001);
      repeat (6) chk_rd(a_mode, 16'h0001);
      check({15'h0, line}, 16'h0000);
      wr(a_mode, 16'h0000);
      wr(frtcc_pkg::ADDR_PORT2_DATA, 16'h0040);
      chk_rd(frtcc_pkg::ADDR_PORT2_DATA, 16'h0040);
      check({15'h0, pin}, 16'h0001);
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_mode();
      t_rates();
      t_capture();
      t_output();
      summarize();
   end
   // Scenarios need about 66k cycles, the full wrap dominating
   initial
   begin
      repeat (90000) @(posedge clk);
      fails++;
      summarize();
   end
endmodule
bind frtcc_timer frtcc_timer_monitor mon_u (.SYS_CLK, .RST_N, .ADDR, .WR_EN, .WR_WORD,
   .WR_DATA, .RD_EN, .RD_DATA, .CAPTURE_TRIGGER_PIN, .TIMER_OUTPUT_PIN,
   .TIMER_OUTPUT_PIN_OE, .COMPARE_IRQ);
